// [pgsm_status_mask.sv]
// power-good status register, fault mask register and open-drain interrupt output
// Operation
// - status bit 7 is one while power-fail sense is below threshold
// - status bit 6 is one while low-battery sense is below threshold
// - status bit 5 flags core buck low; zero when in range or disabled
// - status bit 4 flags system buck low; zero when in range or disabled
// - status bit 3 flags memory buck low; zero when disabled or scaling
// - status bit 2 flags linear regulator b low; zero when fine or disabled
// - status bit 1 flags linear regulator a low; zero when fine or disabled
// - status register at 01h is read-only and resets to zero
// - mask at 02h resets bits 7,6 high, 5..1 low, bit 0 reads zero
// - a set mask bit keeps its status flag off the interrupt
// - interrupt pulls low while any unmasked status bit is one
// - reading status while interrupt is active releases the pin
// - unlisted register reads return ffh over the serial port
`include "pgsm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module pgsm_status_mask (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic power_fail_sense_i,      // comparator: 1 = below 1 V
    input wire logic low_battery_sense_i,     // comparator: 1 = below 1 V
    input wire logic core_buck_low_i,
    input wire logic system_buck_low_i,
    input wire logic memory_buck_low_i,
    input wire logic linear_reg_b_low_i,
    input wire logic linear_reg_a_low_i,
    input wire logic core_buck_en_i,
    input wire logic system_buck_en_i,
    input wire logic memory_buck_en_i,
    input wire logic linear_reg_b_en_i,
    input wire logic linear_reg_a_en_i,
    input wire logic dynamic_voltage_scaling_i, // high during a scaled transition
    input wire logic reg_wr_i,                // one-cycle write strobe from serial engine
    input wire logic reg_rd_i,                // one-cycle read strobe from serial engine
    input wire pgsm_pkg::pgsm_addr_t reg_addr_i,
    input wire pgsm_pkg::pgsm_byte_t reg_wdata_i,
    output pgsm_pkg::pgsm_byte_t reg_rdata_o,
    output logic int_o,                       // open-drain data, always low
    output logic int_oe_b_o                   // low = pin pulled low
);
    import pgsm_pkg::*;

    // ----------------------------------------
    // synchronisers for the analog flags
    // ----------------------------------------
    localparam int NF = 12;

    // where each pin sits inside the synchroniser vector; keep in step with raw_w below
    localparam int IX_PF = 11;
    localparam int IX_LB = 10;
    localparam int IX_CORE_LO = 9;
    localparam int IX_SYS_LO = 8;
    localparam int IX_MEM_LO = 7;
    localparam int IX_LINB_LO = 6;
    localparam int IX_LINA_LO = 5;
    localparam int IX_CORE_EN = 4;
    localparam int IX_SYS_EN = 3;
    localparam int IX_MEM_EN = 2;
    localparam int IX_LINB_EN = 1;
    localparam int IX_LINA_EN = 0;

    logic [NF-1:0] raw_w;
    logic [NF-1:0] sync1_r;
    logic [NF-1:0] sync2_r;
    // pack the pins so that one generate loop can synchronise them all alike
    assign raw_w = {power_fail_sense_i, low_battery_sense_i, core_buck_low_i, system_buck_low_i,
                    memory_buck_low_i, linear_reg_b_low_i, linear_reg_a_low_i, core_buck_en_i,
                    system_buck_en_i, memory_buck_en_i, linear_reg_b_en_i, linear_reg_a_en_i};

    // comparators are asynchronous to the register clock, so two stages each;
    // only the second stage is read, the first may still be settling
    // enables are synchronised too, so a flag and its gate age by the same two edges
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= raw_w[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    // scaling indicator comes from the converter side, so it gets its own two stages;
    // it only gates the memory rail flag and needs no exact alignment with it
    logic dvs_s1_r;
    logic dvs_s2_r;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dvs_s1_r <= 1'b0;
            dvs_s2_r <= 1'b0;
        end else begin
            dvs_s1_r <= dynamic_voltage_scaling_i;
            dvs_s2_r <= dvs_s1_r;
        end
    end

    // ----------------------------------------
    // status register
    // ----------------------------------------
    pgsm_byte_t status_r;
    pgsm_byte_t status_nxt;
    // next status: comparator flags pass straight, rail flags are gated by their enable
    // so that a switched-off rail never reports a fault; bit 0 stays at zero
    // the memory rail is also quiet while its voltage is being scaled on purpose
    always_comb begin
        status_nxt = `PGSM_STATUS_RST;
        status_nxt[`PGSM_BIT_PWRFAIL] = sync2_r[IX_PF];
        status_nxt[`PGSM_BIT_LOWBAT] = sync2_r[IX_LB];
        status_nxt[`PGSM_BIT_CORE] = sync2_r[IX_CORE_LO] & sync2_r[IX_CORE_EN];
        status_nxt[`PGSM_BIT_SYS] = sync2_r[IX_SYS_LO] & sync2_r[IX_SYS_EN];
        status_nxt[`PGSM_BIT_MEM] = sync2_r[IX_MEM_LO] & sync2_r[IX_MEM_EN] & ~dvs_s2_r;
        status_nxt[`PGSM_BIT_LINB] = sync2_r[IX_LINB_LO] & sync2_r[IX_LINB_EN];
        status_nxt[`PGSM_BIT_LINA] = sync2_r[IX_LINA_LO] & sync2_r[IX_LINA_EN];
    end

    // live flags; writes never reach this register
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_r <= `PGSM_STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    // ----------------------------------------
    // mask register
    // ----------------------------------------
    pgsm_byte_t mask_r;
    // host-written mask; bit 0 is forced to zero on every write so it always reads back 0
    // comparator bits start masked so a drooping battery does not pull the pin at power-up
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_r <= `PGSM_MASK_RST;
        end else if (reg_wr_i && reg_addr_i == `PGSM_MASK_ADDR) begin
            mask_r <= reg_wdata_i & `PGSM_MASK_WMASK;
        end
    end

    // ----------------------------------------
    // interrupt
    // ----------------------------------------
    // the pin follows the unmasked flags, but a status read lets the host silence it
    // while the fault persists; only a flag that newly turns on pulls it low again,
    // and it also re-arms once every unmasked flag has cleared
    // trade-off: a flag that stays high is reported once, not repeatedly
    // limitation: a flag that drops and returns within one cycle counts as a new rise
    pgsm_byte_t active_w;
    pgsm_byte_t prev_active_r;
    logic status_read_w;
    logic rise_w;
    logic released_r;
    assign active_w = status_r & ~mask_r;
    assign status_read_w = reg_rd_i && reg_addr_i == `PGSM_STATUS_ADDR;
    assign rise_w = |(active_w & ~prev_active_r);

    // last cycle's active flags, for the rising-edge test; resets to the idle value
    // so no false rise appears after reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_active_r <= 8'h00;
        end else begin
            prev_active_r <= active_w;
        end
    end

    // a new rising flag wins over a read in the same cycle so it is not lost;
    // the host then sees the pin stay low and reads again
    // clearing on no-active-flags makes the next fault assert without a rise test
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            released_r <= 1'b0;
        end else if (rise_w) begin
            released_r <= 1'b0;
        end else if (status_read_w && |active_w) begin
            released_r <= 1'b1;
        end else if (~|active_w) begin
            released_r <= 1'b0;
        end
    end

    // pin data is a constant low; only the enable moves
    // the read term releases the pin on the edge after the read, one cycle before
    // released_r alone would; registered so the pin never glitches
    logic int_oe_b_r;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_oe_b_r <= 1'b1;
        end else begin
            int_oe_b_r <= ~((|active_w) & ~(released_r | (status_read_w & ~rise_w)));
        end
    end
    assign int_o = 1'b0;
    assign int_oe_b_o = int_oe_b_r;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // read data is captured on the read strobe and held until the next read,
    // so the serial engine may shift it out at its own pace
    // addresses outside this block answer all ones
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= `PGSM_UNMAPPED_DATA;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `PGSM_STATUS_ADDR: reg_rdata_o <= status_r;
                `PGSM_MASK_ADDR: reg_rdata_o <= mask_r;
                default: reg_rdata_o <= `PGSM_UNMAPPED_DATA;
            endcase
        end
    end
endmodule : pgsm_status_mask
`default_nettype wire

// [pgsm_cfg.svh]
// register offsets, reset values and field positions of the power-good status and mask block
`ifndef PGSM_CFG_SVH
`define PGSM_CFG_SVH
`define PGSM_STATUS_ADDR 8'h01
`define PGSM_MASK_ADDR 8'h02
`define PGSM_MASK_RST 8'hc0
`define PGSM_MASK_WMASK 8'hfe
`define PGSM_STATUS_RST 8'h00
`define PGSM_UNMAPPED_DATA 8'hff
`define PGSM_BIT_PWRFAIL 7
`define PGSM_BIT_LOWBAT 6
`define PGSM_BIT_CORE 5
`define PGSM_BIT_SYS 4
`define PGSM_BIT_MEM 3
`define PGSM_BIT_LINB 2
`define PGSM_BIT_LINA 1
`endif

// [pgsm_pkg.sv]
// types shared by the power-good status and mask block
package pgsm_pkg;
    typedef logic [7:0] pgsm_byte_t;
    typedef logic [7:0] pgsm_addr_t;
endpackage : pgsm_pkg

// [pgsm_checker.sv]
// concurrent checks on the ports of the power-good status and mask block
`timescale 1ns/100ps
`default_nettype none
module pgsm_checker (
    input wire logic ref_clk_i, rst_b_i, power_fail_sense_i, low_battery_sense_i, reg_wr_i, reg_rd_i,
    input wire pgsm_pkg::pgsm_addr_t reg_addr_i,
    input wire pgsm_pkg::pgsm_byte_t reg_wdata_i, reg_rdata_o,
    input wire logic int_o, int_oe_b_o
);
    // ----------------------------------------
    // properties, all in the one clock domain
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire logic rd_st = reg_rd_i && reg_addr_i == 8'h01; // status read strobe
    pin_data_a: assert property (int_o == 1'b0) else $error("pin data not low");
    unmapped_ff_a: assert property (reg_rd_i && reg_addr_i != 8'h01 && reg_addr_i != 8'h02
        |=> reg_rdata_o == 8'hff) else $error("unlisted read not ff");
    mask_bit0_a: assert property (reg_rd_i && reg_addr_i == 8'h02 |=> !reg_rdata_o[0])
        else $error("mask bit 0 not zero");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
    mask_back_a: assert property (reg_wr_i && reg_addr_i == 8'h02 ##2 reg_rd_i && reg_addr_i == 8'h02
        |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'hfe)) else $error("mask readback wrong");
    // three sync edges sit between the sense pin and the status bit
    pf_flag_a: assert property ($stable(power_fail_sense_i)[*4] ##0 rd_st
        |=> reg_rdata_o[7] == $past(power_fail_sense_i)) else $error("power fail flag wrong");
    lb_flag_a: assert property ($stable(low_battery_sense_i)[*4] ##0 rd_st
        |=> reg_rdata_o[6] == $past(low_battery_sense_i)) else $error("low battery flag wrong");
    all_mask_a: assert property (reg_wr_i && reg_addr_i == 8'h02 && reg_wdata_i[7:1] == 7'h7f
        |=> ##1 int_oe_b_o) else $error("masked flags drive pin");
    cover property (rd_st && !int_oe_b_o);
    cover property ($fell(int_oe_b_o));
    cover property (reg_wr_i && reg_addr_i == 8'h02);
endmodule : pgsm_checker
bind pgsm_status_mask pgsm_checker i_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .power_fail_sense_i(power_fail_sense_i), .low_battery_sense_i(low_battery_sense_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .int_o(int_o), .int_oe_b_o(int_oe_b_o));
`default_nettype wire

// [pgsm_host_model.sv]
// host model that issues single-byte register reads and writes
`timescale 1ns/100ps
`default_nettype none
module pgsm_host_model (
    input wire logic clk_i,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output pgsm_pkg::pgsm_addr_t addr_o = 8'h00,
    output pgsm_pkg::pgsm_byte_t data_o = 8'h00
);
    // one strobe edge; released lines flip so stale values never look valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {wr_o, rd_o, addr_o, data_o} <= {w, !w, a, d};
        @(posedge clk_i);
        {wr_o, rd_o, addr_o, data_o} <= {2'b00, ~a, ~d};
    endtask : xfer
endmodule : pgsm_host_model
`default_nettype wire

// [test_pgsm_status_mask.sv]
// self-checking bench for the power-good status and mask block
`timescale 1ns/100ps
`default_nettype none
module test_pgsm_status_mask;
    import pgsm_pkg::*;
    logic ref_clk_i = 0, rst_b_i = 0, dvs = 0, rd_seen = 0, wr, rd, int_d, int_oe_b;
    logic [6:0] fl = 0;
    logic [4:0] en = 0;
    logic [31:0] seed = 32'hcdbb;
    int mismatches = 0, total_checks = 0, cycles = 0;
    pgsm_byte_t exp_q[$], wdata, rdata;
    pgsm_addr_t addr;
    pgsm_host_model i_host (.clk_i(ref_clk_i), .wr_o(wr), .rd_o(rd), .addr_o(addr), .data_o(wdata));
    pgsm_status_mask i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .power_fail_sense_i(fl[6]),
        .low_battery_sense_i(fl[5]), .core_buck_low_i(fl[4]), .system_buck_low_i(fl[3]),
        .memory_buck_low_i(fl[2]), .linear_reg_b_low_i(fl[1]), .linear_reg_a_low_i(fl[0]),
        .core_buck_en_i(en[4]), .system_buck_en_i(en[3]), .memory_buck_en_i(en[2]),
        .linear_reg_b_en_i(en[1]), .linear_reg_a_en_i(en[0]), .dynamic_voltage_scaling_i(dvs),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .int_o(int_d), .int_oe_b_o(int_oe_b));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input pgsm_byte_t s, input pgsm_byte_t e);
        total_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic rd_exp(input pgsm_addr_t a, input pgsm_byte_t e);
        i_host.xfer(1'b0, a, 8'h00);
        exp_q.push_back(e);
    endtask : rd_exp
    // a flag change needs three edges to reach status, one more for the pin
    task automatic set_in(input logic [6:0] f);
        @(posedge ref_clk_i);
        fl <= f;
        repeat (6) @(posedge ref_clk_i);
    endtask : set_in
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial forever #5 ref_clk_i = ~ref_clk_i;
    // read data lands one edge after its strobe; the oldest note is compared
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (rd_seen) chk("rdata", rdata, exp_q.pop_front());
        rd_seen <= rd;
        if (cycles > 4000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        chk("int", {7'h00, int_oe_b}, 8'h01);
        rd_exp(8'h01, 8'h00);
        rd_exp(8'h02, 8'hc0);
        rd_exp(8'h00, 8'hff);
        rd_exp(8'h03, 8'hff);
        i_host.xfer(1'b1, 8'h01, 8'hff);
        rd_exp(8'h01, 8'h00);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            i_host.xfer(1'b1, 8'h02, k == 0 ? 8'hff : seed[7:0]);
            rd_exp(8'h02, (k == 0 ? 8'hff : seed[7:0]) & 8'hfe);
        end
        en <= 5'h1f;
        for (int i = 0; i < 7; i++) begin
            i_host.xfer(1'b1, 8'h02, 8'h02 << i);
            set_in(7'h01 << i);
            chk("masked", {7'h00, int_oe_b}, 8'h01);
            rd_exp(8'h01, 8'h02 << i);
            i_host.xfer(1'b1, 8'h02, 8'h00);
            repeat (2) @(posedge ref_clk_i);
            chk("active", {7'h00, int_oe_b}, 8'h00);
            rd_exp(8'h01, 8'h02 << i);
            repeat (2) @(posedge ref_clk_i);
            chk("released", {7'h00, int_oe_b}, 8'h01);
            set_in((7'h01 << i) | (7'h01 << ((i + 1) % 7)));
            chk("again", {7'h00, int_oe_b}, 8'h00);
            set_in(7'h00);
            chk("clear", {7'h00, int_oe_b}, 8'h01);
        end
        en <= 5'h00;
        set_in(7'h1f);
        rd_exp(8'h01, 8'h00);
        en <= 5'h1f;
        dvs <= 1'b1;
        set_in(7'h1f);
        rd_exp(8'h01, 8'h36);
        repeat (3) @(posedge ref_clk_i);
        print_verdict();
    end
endmodule : test_pgsm_status_mask
`default_nettype wire
